// file: hdl/scd_defines.vh
`ifndef SCD_DEFINES_VH
`define SCD_DEFINES_VH

// Register offsets on the plain register port.
`define SCD_ADDR_CTRL 4'h0
`define SCD_ADDR_OVR 4'h1
`define SCD_ADDR_STATUS 4'h2
`define SCD_ADDR_PINS 4'h3

// Field positions in the control and override registers.
`define SCD_BIT_LANE 0
`define SCD_BIT_MODE_LO 1
`define SCD_BIT_MODE_HI 2
`define SCD_BIT_BIST 3
`define SCD_BIT_SWING 4
`define SCD_BIT_DEEMPH 5

// Reset values.
`define SCD_CTRL_RST 6'h00
`define SCD_OVR_RST 6'h00

// Operating mode codes.
`define SCD_MODE_NATIVE 2'h0
`define SCD_MODE_NATIVE_FLT 2'h1
`define SCD_MODE_LEGACY_A 2'h2
`define SCD_MODE_LEGACY_B 2'h3

// Cycles of settling after power-down release before pins are sampled.
`define SCD_SAMPLE_DELAY 4'h2

`endif

// file: hdl/scd_lane_map.v
`timescale 1ns/1ps
`default_nettype none

// Places the high or low half of the parallel word on lane 3.
module scd_lane_map
(
  // Control
  input wire i_lane_order_select,
  // Data
  input wire [7:0] i_word_lo,
  input wire [7:0] i_word_hi,
  output wire [7:0] o_lane3,
  output wire [7:0] o_lane_other
);

  assign o_lane3 = i_lane_order_select ? i_word_hi : i_word_lo;
  assign o_lane_other = i_lane_order_select ? i_word_lo : i_word_hi;

endmodule // scd_lane_map

`default_nettype wire

// file: hdl/scd_mode_decode.v
`timescale 1ns/1ps
`default_nettype none
`include "scd_defines.vh"

// Decodes the two-bit operating mode into one-hot native/legacy settings, with the filter enable set alongside native in mode 01 only.
module scd_mode_decode
(
  input wire [1:0] i_mode,
  output reg o_native,
  output reg o_filter_en,
  output reg o_legacy_a,
  output reg o_legacy_b
);

  always @*
  begin
    o_native = 1'b0;
    o_filter_en = 1'b0;
    o_legacy_a = 1'b0;
    o_legacy_b = 1'b0;
    case (i_mode)
      `SCD_MODE_NATIVE:
      begin
        o_native = 1'b1;
      end
      `SCD_MODE_NATIVE_FLT:
      begin
        o_native = 1'b1;
        o_filter_en = 1'b1;
      end
      `SCD_MODE_LEGACY_A:
      begin
        o_legacy_a = 1'b1;
      end
      default:
      begin
        o_legacy_b = 1'b1;
      end
    endcase
  end

endmodule // scd_mode_decode

`default_nettype wire

// file: hdl/scd_config.v
// Overview of operation
// [R1] Lane order select high puts the word's most significant bits on lane 3.
// [R2] Lane order select low puts the word's least significant bits on lane 3.
// [R3] Mode 00: native companion far end, control-signal filter off.
// [R4] Mode 01: native companion far end, control-signal filter on.
// [R5] Modes 10 and 11 select two distinct legacy far-end compatibility modes.
// [R6] Self-test mode follows the self-test enable setting, on when high.
// [R7] Output swing from pin or register; high selects long-cable swing.
// [R8] Power-down low powers down and returns all control registers to reset.
// [R9] Pins sampled after power-down release; register write overrides until next power-down.
`timescale 1ns/1ps
`default_nettype none
`include "scd_defines.vh"

module scd_config
(
  // Clock and reset
  input wire i_mclk,
  input wire i_rst,
  // Configuration pins
  input wire i_power_down_n,
  input wire i_lane_order_select,
  input wire [1:0] i_mode,
  input wire i_self_test_enable,
  input wire i_output_swing_select,
  input wire i_deemphasis_control,
  // Register port
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // Parallel word
  input wire [15:0] i_word,
  output reg [7:0] o_lane3,
  output reg [7:0] o_lane_other,
  // Decoded settings
  output wire o_powered,
  output wire o_native,
  output wire o_filter_en,
  output wire o_legacy_a,
  output wire o_legacy_b,
  output wire o_self_test,
  output wire o_long_swing,
  output wire o_deemph_en
);

  ////////////////////////////////////////////////////////////////////////////
  // State.
  reg [5:0] pins_reg;
  reg [5:0] ctrl_reg;
  reg [5:0] ovr_reg;
  reg [3:0] dly_reg;
  reg sampled_reg;
  wire [5:0] pin_now;
  wire [5:0] eff;
  wire pd_active;
  wire [7:0] lane3_w;
  wire [7:0] other_w;

  assign pd_active = ~i_power_down_n;
  assign pin_now = {i_deemphasis_control, i_output_swing_select, i_self_test_enable,
                    i_mode, i_lane_order_select};

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling after power-down release, and register writes.
  always @(posedge i_mclk)
  begin
    if (i_rst || pd_active) // [R8]
    begin
      pins_reg <= `SCD_CTRL_RST;
      ctrl_reg <= `SCD_CTRL_RST;
      ovr_reg <= `SCD_OVR_RST;
      dly_reg <= 4'h0;
      sampled_reg <= 1'b0;
    end
    else
    begin
      if (!sampled_reg)
      begin
        if (dly_reg == `SCD_SAMPLE_DELAY)
        begin
          pins_reg <= pin_now; // [R9]
          sampled_reg <= 1'b1;
        end
        else
        begin
          dly_reg <= dly_reg + 4'h1;
        end
      end
      if (i_wr && i_addr == `SCD_ADDR_CTRL)
      begin
        ctrl_reg <= i_wdata[5:0];
      end
      if (i_wr && i_addr == `SCD_ADDR_OVR)
      begin
        ovr_reg <= i_wdata[5:0]; // [R9]
      end
    end
  end

  // Each override bit picks the register value over the sampled pin value.
  assign eff = (ovr_reg & ctrl_reg) | (~ovr_reg & pins_reg); // [R7] [R9]

  ////////////////////////////////////////////////////////////////////////////
  // Read port, data one cycle after the strobe.
  always @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      o_rdata <= 8'h00;
    end
    else if (i_rd)
    begin
      case (i_addr)
        `SCD_ADDR_CTRL: o_rdata <= {2'h0, ctrl_reg};
        `SCD_ADDR_OVR: o_rdata <= {2'h0, ovr_reg};
        `SCD_ADDR_STATUS: o_rdata <= {sampled_reg, i_power_down_n, eff};
        `SCD_ADDR_PINS: o_rdata <= {2'h0, pins_reg};
        default: o_rdata <= 8'h00;
      endcase
    end
    else
    begin
      o_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Settings outputs; power, self-test, swing and de-emphasis are forced off until pins are sampled, mode outputs are not.
  assign o_powered = sampled_reg;
  assign o_self_test = sampled_reg & eff[`SCD_BIT_BIST]; // [R6]
  assign o_long_swing = sampled_reg & eff[`SCD_BIT_SWING]; // [R7]
  assign o_deemph_en = sampled_reg & eff[`SCD_BIT_DEEMPH];

  scd_mode_decode u_mode
  (
    .i_mode(eff[`SCD_BIT_MODE_HI:`SCD_BIT_MODE_LO]), // [R3] [R4] [R5]
    .o_native(o_native),
    .o_filter_en(o_filter_en),
    .o_legacy_a(o_legacy_a),
    .o_legacy_b(o_legacy_b)
  );

  scd_lane_map u_map
  (
    .i_lane_order_select(eff[`SCD_BIT_LANE]), // [R1] [R2]
    .i_word_lo(i_word[7:0]),
    .i_word_hi(i_word[15:8]),
    .o_lane3(lane3_w),
    .o_lane_other(other_w)
  );

  // Lane data registered; cleared while powered down.
  always @(posedge i_mclk)
  begin
    if (i_rst || pd_active)
    begin
      o_lane3 <= 8'h00;
      o_lane_other <= 8'h00;
    end
    else
    begin
      o_lane3 <= lane3_w; // [R1] [R2]
      o_lane_other <= other_w;
    end
  end

endmodule // scd_config

`default_nettype wire

// file: verification/scd_strap.sv
`timescale 1ns/1ps
`default_nettype none
// Board strap driver: holds requested pin levels, changing only after a clock edge.
module scd_strap (
  // Requested and driven levels
  input wire logic i_mclk,
  input wire logic [6:0] i_req,
  output var logic [6:0] o_pins
);
  initial o_pins = 7'h00;
  always @(posedge i_mclk)
    o_pins <= i_req;
endmodule // scd_strap
`default_nettype wire

// file: verification/scd_config_properties.sv
`timescale 1ns/1ps
`default_nettype none
module scd_config_properties (
  // Watched ports
  input wire i_mclk,
  input wire i_rst,
  input wire i_power_down_n,
  input wire [15:0] i_word,
  input wire [7:0] o_lane3,
  input wire [7:0] o_lane_other,
  input wire o_powered,
  input wire o_native,
  input wire o_filter_en,
  input wire o_legacy_a,
  input wire o_legacy_b,
  input wire o_self_test
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  a_pd_off: assert property (!i_power_down_n |=> !o_powered) else $error("pd");
  a_pd_lane: assert property (!i_power_down_n |=> o_lane3 == 8'h00) else $error("lz");
  a_power_up: assert property (i_power_down_n [*5] |-> o_powered) else $error("up");
  a_early_up: assert property ($rose(i_power_down_n) |-> !o_powered ##1 !o_powered)
    else $error("early");
  a_lane_map: assert property (o_powered && $past(o_powered) |->
    {o_lane3, o_lane_other} == $past(i_word) || {o_lane_other, o_lane3} == $past(i_word))
    else $error("lane");
  a_mode_hot: assert property ($onehot({o_native, o_legacy_a, o_legacy_b}))
    else $error("mode");
  a_filt_nat: assert property (o_filter_en |-> o_native) else $error("filter");
  a_test_off: assert property (!o_powered |-> !o_self_test) else $error("test");
endmodule // scd_config_properties
bind scd_config scd_config_properties u_chk (.*);
`default_nettype wire

// file: verification/scd_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("wrong value at %0t: %h", $time, a); end end
module scd_config_tb;
  logic i_mclk = 0, i_rst = 1, i_wr = 0, i_rd = 0;
  logic [3:0] i_addr = 0;
  logic [7:0] i_wdata = 0, o_rdata, o_lane3, o_lane_other;
  logic [15:0] i_word = 0;
  logic [6:0] req = 0, p;
  logic [5:0] c;
  logic o_powered, o_native, o_filter_en, o_legacy_a, o_legacy_b;
  logic o_self_test, o_long_swing, o_deemph_en;
  int miscompares = 0, num_checks = 0, seed = 36;
  initial forever #5 i_mclk = ~i_mclk;
  scd_strap i_strap (.i_mclk, .i_req(req), .o_pins(p));
  scd_config i_dut (.*, .i_power_down_n(p[6]), .i_lane_order_select(p[0]), .i_mode(p[2:1]),
    .i_self_test_enable(p[3]), .i_output_swing_select(p[4]), .i_deemphasis_control(p[5]));
  function automatic logic [7:0] exp_set(input logic [5:0] s);
    exp_set = {1'b1, s[2:1] < 2'h2, s[2:1] == 2'h1, s[2:1] == 2'h2, s[2:1] == 2'h3,
      s[3], s[4], s[5]};
  endfunction
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    @(posedge i_mclk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 `CHK(o_rdata, e)
    @(posedge i_mclk);
  endtask
  task automatic boot(input logic [5:0] s);
    req <= {1'b0, s};
    repeat (3) @(posedge i_mclk);
    req <= {1'b1, s};
    repeat (7) @(posedge i_mclk);
  endtask
  task automatic chk(input logic [5:0] s);
    i_word <= $random(seed);
    repeat (2) @(posedge i_mclk);
    #1 `CHK({o_powered, o_native, o_filter_en, o_legacy_a, o_legacy_b, o_self_test,
      o_long_swing, o_deemph_en}, exp_set(s))
    `CHK(o_lane3, s[0] ? i_word[15:8] : i_word[7:0])
    `CHK(o_lane_other, s[0] ? i_word[7:0] : i_word[15:8])
    @(posedge i_mclk);
  endtask
  task automatic give_verdict;
    $display("checks %0d, miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge i_mclk);
    i_rst <= 1'b0;
    for (int m = 0; m < 10; m++)
    begin
      c = $random(seed);
      if (m < 8)
        c[2:0] = m[2:0];
      boot(c);
      chk(c);
    end
    $display("test pins done");
    // Register values take over every setting until the next power-down.
    wr(4'h1, 8'h3f);
    wr(4'h0, {2'h0, ~c});
    chk(~c);
    rd(4'h0, {2'h0, ~c});
    rd(4'h2, {2'h3, ~c});
    rd(4'h3, {2'h0, c});
    rd(4'h5, 8'h00);
    boot(c);
    rd(4'h1, 8'h00);
    chk(c);
    $display("test override done");
    give_verdict;
  end
  initial
  begin
    #20000;
    miscompares++;
    give_verdict;
  end
endmodule // scd_config_tb
`default_nettype wire
